// ==== verilog/tsws_slave.sv ====
// single-wire thermometer slave: slot timing, command decode, buffer and limit store
`timescale 1ns/1ps
module tsws_slave #(
  parameter int RESET_LOW_CYC = tsws_pkg::RESET_CYC,
  parameter int CONV_DUR_CYC  = tsws_pkg::CONV_CYC,
  parameter int COPY_DUR_CYC  = tsws_pkg::COPY_CYC
) (
  input  wire logic        clock_i,
  input  wire logic        resetn_i,
  input  wire logic        clk_en_i,
  input  wire logic        dq_i,
  output logic             dq_o,
  output logic             dq_oe_n_o,
  input  wire logic        ext_supply_i,
  input  wire logic [15:0] temp_sample_i,
  output logic [15:0]      measured_temperature_o,
  output logic [7:0]       upper_alarm_limit_o,
  output logic [7:0]       lower_alarm_limit_o,
  output logic             busy_o
);
  localparam logic [12:0] RST_CNT  = 13'(RESET_LOW_CYC);
  localparam logic [22:0] CONV_CNT = 23'(CONV_DUR_CYC);
  localparam logic [22:0] COPY_CNT = 23'(COPY_DUR_CYC);

  typedef struct packed {
    logic [2:0]         sync;
    logic               line;
    tsws_pkg::tsws_st_e st;
    tsws_pkg::tsws_ph_e ph;
    logic [12:0]        cnt;
    logic [7:0]         sh;
    logic [2:0]         bit_cnt;
    logic [3:0]         idx;
    logic [7:0]         crc;
    logic               oe_n;
    tsws_pkg::tsws_op_e op;
    logic [22:0]        op_cnt;
    logic               busy;
    logic [15:0]        temp;
    logic [7:0]         upper;
    logic [7:0]         lower;
    logic [7:0]         nv_upper;
    logic [7:0]         nv_lower;
  } tsws_state_s;

  tsws_state_s s;
  tsws_state_s n;
  logic        rst_meta_r;
  logic        rst_n_r;
  logic        fell;
  logic        rose;
  logic        bit_ok;
  logic        bit_val;
  logic        out_bit;
  logic [7:0]  byte_v;

  // one step of the buffer checksum, fed LSB first
  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic b);
    logic fb;
    fb = c[0] ^ b;
    crc_step = {1'b0, c[7:1]} ^ (fb ? tsws_pkg::CRC_POLY : 8'h00);
  endfunction

  // buffer byte by index; unused bytes read as all ones
  function automatic logic [7:0] buf_byte(input tsws_state_s x);
    case (x.idx)
      tsws_pkg::IDX_TEMP_LO: buf_byte = x.temp[7:0];
      tsws_pkg::IDX_TEMP_HI: buf_byte = x.temp[15:8];
      tsws_pkg::IDX_UPPER:   buf_byte = x.upper;
      tsws_pkg::IDX_LOWER:   buf_byte = x.lower;
      tsws_pkg::IDX_CRC:     buf_byte = x.crc;
      default:               buf_byte = tsws_pkg::RSV_BYTE;
    endcase
  endfunction

  function automatic logic is_write_ph(input tsws_pkg::tsws_ph_e p);
    is_write_ph = (p == tsws_pkg::PH_ADDR) || (p == tsws_pkg::PH_FUNC) ||
                  (p == tsws_pkg::PH_WR_UP) || (p == tsws_pkg::PH_WR_LO);
  endfunction

  // reset release through two flops
  always_ff @(posedge clock_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rst_meta_r <= 1'b0;
      rst_n_r    <= 1'b0;
    end else if (clk_en_i) begin
      rst_meta_r <= 1'b1;
      rst_n_r    <= rst_meta_r;
    end
  end

  // next-state logic for the whole block
  always_comb begin
    n       = s;
    bit_ok  = 1'b0;
    bit_val = 1'b0;
    out_bit = 1'b1;
    byte_v  = buf_byte(s);
    // line filter: a change counts once the last two stages agree
    n.sync = {s.sync[1:0], dq_i};
    if (s.sync[1] == s.sync[2]) n.line = s.sync[2];
    fell = s.line & ~n.line;
    rose = ~s.line & n.line;
    if (fell || rose) n.cnt = 13'h0000;
    else if (s.cnt != tsws_pkg::CNT_MAX) n.cnt = s.cnt + 13'h0001;

    case (s.st)
      tsws_pkg::ST_IDLE: if (fell) begin
        n.st = tsws_pkg::ST_SLOT;
        // reply bit chosen at the slot edge so it is valid at once
        case (s.ph)
          tsws_pkg::PH_DUMP:   out_bit = byte_v[s.bit_cnt];
          tsws_pkg::PH_STATUS: out_bit = (s.op == tsws_pkg::OP_NONE);
          tsws_pkg::PH_SUPPLY: out_bit = ext_supply_i;
          default:             out_bit = 1'b1;
        endcase
        n.oe_n = out_bit;
        if (s.ph == tsws_pkg::PH_DUMP) begin
          if (s.idx != tsws_pkg::IDX_CRC) n.crc = crc_step(s.crc, out_bit);
          n.bit_cnt = s.bit_cnt + 3'h1;
          if (s.bit_cnt == 3'h7) begin
            if (s.idx == tsws_pkg::IDX_CRC) n.ph = tsws_pkg::PH_IGNORE;
            else n.idx = s.idx + 4'h1;
          end
        end
      end
      tsws_pkg::ST_SLOT: begin
        // release before the slot can end; master sampled within 15 us
        if (!s.oe_n && s.cnt == tsws_pkg::HOLD_CNT) n.oe_n = 1'b1;
        if (rose) begin
          // released before the sample point: line high there
          bit_ok  = 1'b1;
          bit_val = 1'b1;
          n.st    = tsws_pkg::ST_IDLE;
        end else if (s.cnt == tsws_pkg::SAMPLE_CNT) begin
          bit_ok  = 1'b1;
          bit_val = s.line;
          n.st    = tsws_pkg::ST_TAIL;
        end
      end
      tsws_pkg::ST_TAIL: begin
        if (rose) n.st = tsws_pkg::ST_IDLE;
        else if (s.cnt == RST_CNT) begin
          n.st   = tsws_pkg::ST_RST;
          n.ph   = tsws_pkg::PH_IGNORE;
          n.oe_n = 1'b1;
        end
      end
      tsws_pkg::ST_RST: if (rose) n.st = tsws_pkg::ST_PWAIT;
      tsws_pkg::ST_PWAIT: if (s.cnt == tsws_pkg::PWAIT_CNT) begin
        n.oe_n = 1'b0;
        n.st   = tsws_pkg::ST_PRES;
      end
      // count restarts at our own falling edge, so width is from the line
      tsws_pkg::ST_PRES: if (s.cnt == tsws_pkg::PRES_CNT) begin
        n.oe_n = 1'b1;
        n.st   = tsws_pkg::ST_PEND;
      end
      tsws_pkg::ST_PEND: if (rose) begin
        n.st      = tsws_pkg::ST_IDLE;
        n.ph      = tsws_pkg::PH_ADDR;
        n.bit_cnt = 3'h0;
      end
      default: n.st = tsws_pkg::ST_IDLE;
    endcase

    // background operation timer
    if (s.op != tsws_pkg::OP_NONE) begin
      if (s.op_cnt == 23'h000000) begin
        case (s.op)
          tsws_pkg::OP_CONV: n.temp = temp_sample_i;
          tsws_pkg::OP_COPY: begin
            n.nv_upper = s.upper;
            n.nv_lower = s.lower;
          end
          default: begin
            n.upper = s.nv_upper;
            n.lower = s.nv_lower;
          end
        endcase
        n.op = tsws_pkg::OP_NONE;
      end else n.op_cnt = s.op_cnt - 23'h000001;
    end

    // byte assembly in host-to-device phases, LSB first
    if (bit_ok && is_write_ph(s.ph)) begin
      byte_v    = {bit_val, s.sh[7:1]};
      n.sh      = byte_v;
      n.bit_cnt = s.bit_cnt + 3'h1;
      if (s.bit_cnt == 3'h7) begin
        n.ph = tsws_pkg::PH_IGNORE;
        case (s.ph)
          tsws_pkg::PH_ADDR:
            if (byte_v == tsws_pkg::CMD_SKIP_ADDR) n.ph = tsws_pkg::PH_FUNC;
          tsws_pkg::PH_FUNC: begin
            case (byte_v)
              tsws_pkg::CMD_MEASURE: begin
                n.op     = tsws_pkg::OP_CONV;
                n.op_cnt = CONV_CNT;
                n.ph     = tsws_pkg::PH_STATUS;
              end
              tsws_pkg::CMD_LOAD_LIM: n.ph = tsws_pkg::PH_WR_UP;
              tsws_pkg::CMD_DUMP_BUF: begin
                n.ph  = tsws_pkg::PH_DUMP;
                n.idx = tsws_pkg::IDX_TEMP_LO;
                n.crc = 8'h00;
              end
              tsws_pkg::CMD_STORE_LIM: begin
                n.op     = tsws_pkg::OP_COPY;
                n.op_cnt = COPY_CNT;
              end
              tsws_pkg::CMD_RELOAD: begin
                n.op     = tsws_pkg::OP_LOAD;
                n.op_cnt = tsws_pkg::RELOAD_CNT;
                n.ph     = tsws_pkg::PH_STATUS;
              end
              tsws_pkg::CMD_SUPPLY: n.ph = tsws_pkg::PH_SUPPLY;
              default: n.ph = tsws_pkg::PH_IGNORE;
            endcase
          end
          tsws_pkg::PH_WR_UP: begin
            n.upper = byte_v;
            n.ph    = tsws_pkg::PH_WR_LO;
          end
          default: n.lower = byte_v;
        endcase
      end
    end
    n.busy = (n.op != tsws_pkg::OP_NONE);
  end

  // state register; power-up starts with the limit reload running
  always_ff @(posedge clock_i or negedge rst_n_r) begin
    if (!rst_n_r) begin
      s          <= '0;
      s.sync     <= 3'h7;
      s.line     <= 1'b1;
      s.st       <= tsws_pkg::ST_IDLE;
      s.ph       <= tsws_pkg::PH_IGNORE;
      s.oe_n     <= 1'b1;
      s.op       <= tsws_pkg::OP_LOAD;
      s.op_cnt   <= tsws_pkg::RELOAD_CNT;
      s.busy     <= 1'b1;
      s.nv_upper <= tsws_pkg::NV_UPPER_RST;
      s.nv_lower <= tsws_pkg::NV_LOWER_RST;
    end else if (clk_en_i) begin
      s <= n;
    end
  end

  // open-drain: only ever pulls low
  assign dq_o                   = 1'b0;
  assign dq_oe_n_o              = s.oe_n;
  assign measured_temperature_o = s.temp;
  assign upper_alarm_limit_o    = s.upper;
  assign lower_alarm_limit_o    = s.lower;
  assign busy_o                 = s.busy;

  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rst_n_r);

  sequence drive_low_seq;
    !dq_oe_n_o [*8];
  endsequence
  sequence pres_arm_seq;
    s.st == tsws_pkg::ST_PWAIT && s.cnt == tsws_pkg::PWAIT_CNT && clk_en_i;
  endsequence

  presence_start_a: assert property (pres_arm_seq |=> !dq_oe_n_o ##0 drive_low_seq)
    else $error("presence pulse not started");
  presence_end_a: assert property ((s.st == tsws_pkg::ST_PRES && s.cnt == tsws_pkg::PRES_CNT
      && clk_en_i) |=> dq_oe_n_o && s.st == tsws_pkg::ST_PEND)
    else $error("presence pulse not released");
  reset_detect_a: assert property ((s.st == tsws_pkg::ST_TAIL && !rose && s.cnt == RST_CNT
      && clk_en_i) |=> s.st == tsws_pkg::ST_RST && s.ph == tsws_pkg::PH_IGNORE)
    else $error("long low not taken as reset");
  read_zero_a: assert property (($fell(dq_oe_n_o) && s.st == tsws_pkg::ST_SLOT)
      |-> drive_low_seq)
    else $error("read zero released too early");
  read_release_a: assert property ((s.st == tsws_pkg::ST_SLOT && !dq_oe_n_o
      && s.cnt == tsws_pkg::HOLD_CNT && clk_en_i) |=> dq_oe_n_o)
    else $error("read zero not released");
  supply_reply_a: assert property ((s.st == tsws_pkg::ST_IDLE && fell && clk_en_i
      && s.ph == tsws_pkg::PH_SUPPLY) |=> dq_oe_n_o == $past(ext_supply_i))
    else $error("wrong supply reply");
  status_reply_a: assert property ((s.st == tsws_pkg::ST_IDLE && fell && clk_en_i
      && s.ph == tsws_pkg::PH_STATUS) |=> dq_oe_n_o == !$past(busy_o))
    else $error("wrong busy reply");
  conv_store_a: assert property ((s.op == tsws_pkg::OP_CONV && s.op_cnt == 23'h000000
      && clk_en_i) |=> measured_temperature_o == $past(temp_sample_i))
    else $error("conversion result not stored");
  limit_write_a: assert property ((s.ph == tsws_pkg::PH_WR_UP && bit_ok && s.bit_cnt == 3'h7
      && clk_en_i) |=> upper_alarm_limit_o == $past(byte_v)
      && s.ph == tsws_pkg::PH_WR_LO)
    else $error("upper limit not written");
  power_reload_a: assert property ($rose(rst_n_r) |-> busy_o
      && s.op == tsws_pkg::OP_LOAD)
    else $error("no reload after power-up");
endmodule // tsws_slave

// ==== verilog/tsws_pkg.sv ====
// constants and types for the thermometer single-wire slave
//
// Overview of operation
// - start-measurement runs one conversion, stores two temperature bytes, returns to idle.
// - with external supply, read slots after start-measurement return 0 busy, 1 done.
// - load-limits takes two bytes LSB first into buffer bytes 2 then 3.
// - dump-buffer shifts bytes 0 to 8 out, LSB of byte 0 first, CRC last.
// - a reset pulse may stop a buffer read anywhere; the device drops it cleanly.
// - store-limits copies buffer bytes 2 and 3 into nonvolatile memory.
// - reload-limits copies stored limits into bytes 2 and 3; read slots report busy.
// - the limit reload also runs by itself at power-up.
// - after query-supply, bus-powered devices pull the read slot low, others leave high.
// - the master starts every slot; only presence starts from the device.
// - after reset ends, wait 15 to 60 us, then presence low 60 to 240 us.
// - each time slot carries exactly one data bit.
// - the device samples 15 to 60 us after the slot falling edge.
// - function commands need reset, presence and a valid addressing byte first.
// - every command and data byte travels least significant bit first.
// - a line held low over 480 us is a reset in any state; the code detects it only after a slot starts, not in presence states.
// - read slot 0 pulls low, valid 15 us, released before slot end.
package tsws_pkg;
  localparam int CLK_NS      = 100;        // 10 MHz clock period
  // bus timing, figures in microseconds or milliseconds
  localparam int RESET_US    = 480;
  localparam int PWAIT_US    = 30;         // presence delay, inside 15..60
  localparam int PRES_US     = 120;        // presence width, inside 60..240
  localparam int HOLD_US     = 20;         // read-0 drive, beyond the 15 us valid time
  localparam int SAMPLE_US   = 30;         // write sample point, inside 15..60
  localparam int RELOAD_US   = 1;
  localparam int CONV_MS     = 750;
  localparam int COPY_MS     = 10;
  // derived cycle counts, least times rounded up
  localparam int RESET_CYC   = (RESET_US * 1000 + CLK_NS - 1) / CLK_NS;
  localparam int CONV_CYC    = (CONV_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam int COPY_CYC    = (COPY_MS * 1000000 + CLK_NS - 1) / CLK_NS;
  localparam logic [12:0] PWAIT_CNT  = 13'((PWAIT_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [12:0] PRES_CNT   = 13'((PRES_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [12:0] HOLD_CNT   = 13'((HOLD_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [12:0] SAMPLE_CNT = 13'((SAMPLE_US * 1000 + CLK_NS - 1) / CLK_NS);
  localparam logic [12:0] CNT_MAX    = 13'h1FFF;
  localparam logic [22:0] RELOAD_CNT = 23'((RELOAD_US * 1000 + CLK_NS - 1) / CLK_NS);
  // command bytes
  localparam logic [7:0] CMD_SKIP_ADDR = 8'hCC;
  localparam logic [7:0] CMD_MEASURE   = 8'h44;
  localparam logic [7:0] CMD_LOAD_LIM  = 8'h4E;
  localparam logic [7:0] CMD_DUMP_BUF  = 8'hBE;
  localparam logic [7:0] CMD_STORE_LIM = 8'h48;
  localparam logic [7:0] CMD_RELOAD    = 8'hB8;
  localparam logic [7:0] CMD_SUPPLY    = 8'hB4;
  // buffer layout
  localparam logic [3:0] IDX_TEMP_LO = 4'h0;
  localparam logic [3:0] IDX_TEMP_HI = 4'h1;
  localparam logic [3:0] IDX_UPPER   = 4'h2;
  localparam logic [3:0] IDX_LOWER   = 4'h3;
  localparam logic [3:0] IDX_CRC     = 4'h8;
  localparam logic [7:0] RSV_BYTE    = 8'hFF;
  localparam logic [7:0] CRC_POLY    = 8'h8C;  // x8+x5+x4+1, shifted LSB first
  localparam logic [7:0] NV_UPPER_RST = 8'h7F;
  localparam logic [7:0] NV_LOWER_RST = 8'h80;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000, ST_SLOT = 3'b001, ST_TAIL = 3'b010, ST_RST = 3'b011,
    ST_PWAIT = 3'b100, ST_PRES = 3'b101, ST_PEND = 3'b110
  } tsws_st_e;
  typedef enum logic [2:0] {
    PH_IGNORE = 3'b000, PH_ADDR = 3'b001, PH_FUNC = 3'b010, PH_WR_UP = 3'b011,
    PH_WR_LO  = 3'b100, PH_DUMP = 3'b101, PH_STATUS = 3'b110, PH_SUPPLY = 3'b111
  } tsws_ph_e;
  typedef enum logic [1:0] {
    OP_NONE = 2'b00, OP_CONV = 2'b01, OP_COPY = 2'b10, OP_LOAD = 2'b11
  } tsws_op_e;
endpackage

// ==== testbench/tsws_master_model.sv ====
// bus master model for the single-wire thermometer slave
`timescale 1ns/1ps
module tsws_master_model (
  input  wire logic clock_i,
  input  wire logic dev_oe_n_i,
  output logic      line_o
);
  logic pull_low;

  // pull-up wins unless master or device pulls the line
  assign line_o = ~(pull_low | ~dev_oe_n_i);
  initial pull_low = 1'b0;

  // every change lands just after an edge and is held n cycles
  task automatic hold(input int n, input logic low);
    pull_low = low;
    repeat (n) @(posedge clock_i);
    #1;
  endtask

  // line left high, stand-in for the strong pullup: no traffic meanwhile
  task automatic quiet(input int n);
    hold(n, 1'b0);
  endtask

  // reset longer than the shortened count, presence sampled at 20, 60, 160 us
  task automatic bus_reset(output logic [2:0] seen);
    hold(1010, 1'b1); // master starts the reset
    hold(200, 1'b0);
    seen[0] = line_o;
    hold(400, 1'b0);
    seen[1] = line_o;
    hold(1000, 1'b0);
    seen[2] = line_o;
  endtask

  // one bit per slot, 63 us slots with 2 us recovery
  task automatic write_bit(input logic b);
    if (b) begin
      hold(50, 1'b1); // release well inside 15 us
      hold(580, 1'b0);
    end else begin
      hold(610, 1'b1); // low for 61 us, all of the slot but the 2 us recovery
      hold(20, 1'b0);
    end
  endtask

  // short start pulse, sample at 10 us, before the device's 15 us limit
  task automatic read_bit(output logic b);
    hold(10, 1'b1);
    hold(90, 1'b0);
    b = line_o;
    hold(530, 1'b0);
  endtask

  task automatic write_byte(input logic [7:0] v);
    for (int i = 0; i < 8; i++) write_bit(v[i]); // low bit goes first
  endtask
endmodule // tsws_master_model

// ==== testbench/testbench.sv ====
// self-checking bench for the thermometer single-wire slave
`timescale 1ns/1ps
module testbench;
  logic        clock_i;
  logic        resetn_i;
  logic        ext_supply_i;
  logic [15:0] temp_sample_i;
  logic        dq;
  logic        oe_n;
  logic        clk_en;
  logic        dq_drv;
  logic [15:0] temp_o;
  logic [7:0]  upper_o;
  logic [7:0]  lower_o;
  logic        busy_o;
  logic [15:0] exp_q[$];
  logic [15:0] seen_q[$];
  string       name_q[$];
  int          mismatches;
  int          checks_done;
  int          seed;

  // shortened counts keep the run short; reset count stays above a 61 us write 0
  tsws_slave #(.RESET_LOW_CYC(1000), .CONV_DUR_CYC(3000), .COPY_DUR_CYC(2000)) dut (
    .clock_i(clock_i), .resetn_i(resetn_i), .clk_en_i(clk_en), .dq_i(dq), .dq_o(dq_drv),
    .dq_oe_n_o(oe_n), .ext_supply_i(ext_supply_i), .temp_sample_i(temp_sample_i),
    .measured_temperature_o(temp_o), .upper_alarm_limit_o(upper_o),
    .lower_alarm_limit_o(lower_o), .busy_o(busy_o));
  tsws_master_model mst (.clock_i(clock_i), .dev_oe_n_i(oe_n), .line_o(dq));

  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end

  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // driver notes expectation and result together; the monitor pairs them
  task automatic note(input string nm, input logic [15:0] exp, input logic [15:0] seen);
    exp_q.push_back(exp);
    name_q.push_back(nm);
    seen_q.push_back(seen);
  endtask

  always @(negedge clock_i) begin
    while (seen_q.size() > 0) check(name_q.pop_front(), seen_q.pop_front(), exp_q.pop_front());
  end

  task automatic tally_and_finish;
    @(negedge clock_i);
    #1;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic bail;
    mismatches++;
    tally_and_finish();
  endtask

  // reset, presence, addressing byte, then the function byte
  task automatic session(input logic [7:0] fn);
    logic [2:0] pr;
    mst.bus_reset(pr);
    note("presence", 16'h0005, {13'h0000, pr}); // high, low, high again
    mst.write_byte(tsws_pkg::CMD_SKIP_ADDR); // addressing before function
    mst.write_byte(fn);
  endtask

  // read slots until the device reports done, bounded
  task automatic poll_done(input string nm);
    logic b;
    b = 1'b0;
    for (int n = 0; n < 20 && b !== 1'b1; n++) mst.read_bit(b);
    note(nm, 16'h0001, {15'h0000, b}); // done reads as 1
    if (b !== 1'b1) bail();
  endtask

  function automatic logic [7:0] crc8(input logic [63:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 0; i < 64; i++) c = {1'b0, c[7:1]} ^ ((c[0] ^ d[i]) ? 8'h8C : 8'h00);
    return c;
  endfunction

  initial begin
    logic [7:0]  u;
    logic [7:0]  l;
    logic [15:0] t;
    logic [71:0] rd;
    logic [63:0] body;
    logic        b;
    logic [2:0]  pr;
    seed = 20;
    clk_en = 1'b1;
    mismatches = 0;
    checks_done = 0;
    resetn_i = 1'b0;
    ext_supply_i = 1'b1;
    temp_sample_i = 16'h0000;
    u = 8'($random(seed));
    l = 8'($random(seed));
    t = 16'($random(seed));
    repeat (4) @(posedge clock_i);
    #1;
    resetn_i = 1'b1;
    note("busy at release", 16'h0001, {15'h0000, busy_o}); // reload runs by itself
    // freeze the reload part way: without the pause it would finish inside 20 cycles
    mst.quiet(5);
    clk_en = 1'b0;
    mst.quiet(20);
    note("busy while frozen", 16'h0001, {15'h0000, busy_o});
    note("upper while frozen", 16'h0000, {8'h00, upper_o});
    clk_en = 1'b1;
    mst.quiet(20);
    note("upper at power-up", {8'h00, tsws_pkg::NV_UPPER_RST}, {8'h00, upper_o});
    note("lower at power-up", {8'h00, tsws_pkg::NV_LOWER_RST}, {8'h00, lower_o});
    $display("test power-up reload done");
    // both limit bytes always sent before the next reset
    session(tsws_pkg::CMD_LOAD_LIM);
    mst.write_byte(u);
    mst.write_byte(l);
    note("upper", {8'h00, u}, {8'h00, upper_o}); // first byte lands in byte 2
    note("lower", {8'h00, l}, {8'h00, lower_o}); // second byte lands in byte 3
    $display("test load limits done");
    // store on bus power, line held high while busy
    ext_supply_i = 1'b0;
    session(tsws_pkg::CMD_STORE_LIM);
    note("busy in store", 16'h0001, {15'h0000, busy_o}); // copy under way
    for (int n = 0; n < 50 && busy_o !== 1'b0; n++) mst.quiet(100);
    if (busy_o !== 1'b0) bail();
    ext_supply_i = 1'b1;
    session(tsws_pkg::CMD_LOAD_LIM);
    mst.write_byte(~u);
    mst.write_byte(~l);
    note("upper rewritten", {8'h00, ~u}, {8'h00, upper_o});
    session(tsws_pkg::CMD_RELOAD);
    poll_done("reload status");
    note("upper reloaded", {8'h00, u}, {8'h00, upper_o}); // stored copy returns
    note("lower reloaded", {8'h00, l}, {8'h00, lower_o});
    $display("test store and reload done");
    // conversion on external supply with status polling
    temp_sample_i = t;
    session(tsws_pkg::CMD_MEASURE);
    mst.read_bit(b);
    note("conversion busy slot", 16'h0000, {15'h0000, b}); // busy reads as 0
    poll_done("conversion status");
    note("temperature", t, temp_o); // one conversion stored
    note("idle after conversion", 16'h0000, {15'h0000, busy_o});
    $display("test conversion done");
    // full buffer dump with checksum
    session(tsws_pkg::CMD_DUMP_BUF);
    for (int n = 0; n < 72; n++) begin
      mst.read_bit(b);
      rd[n] = b;
    end
    body = {32'hFFFF_FFFF, l, u, t};
    for (int n = 0; n < 9; n++) begin
      note("buffer byte", {8'h00, n < 8 ? body[n*8+:8] : crc8(body)}, {8'h00, rd[n*8+:8]});
    end
    $display("test buffer dump done");
    // dump cut short by a reset, then supply query in both modes
    session(tsws_pkg::CMD_DUMP_BUF);
    for (int n = 0; n < 8; n++) begin
      mst.read_bit(b);
      rd[n] = b;
    end
    note("first byte before abort", {8'h00, t[7:0]}, {8'h00, rd[7:0]});
    session(tsws_pkg::CMD_SUPPLY); // the reset drops the dump
    mst.read_bit(b);
    note("external supply slot", 16'h0001, {15'h0000, b}); // line left high
    ext_supply_i = 1'b0;
    mst.read_bit(b);
    note("bus power slot", 16'h0000, {15'h0000, b}); // line pulled low
    note("drive level", 16'h0000, {15'h0000, dq_drv}); // open drain only pulls low
    // wrong addressing byte: the supply query after it must get no reply
    mst.bus_reset(pr);
    note("presence before bad address", 16'h0005, {13'h0000, pr});
    mst.write_byte(~tsws_pkg::CMD_SKIP_ADDR);
    mst.write_byte(tsws_pkg::CMD_SUPPLY);
    mst.read_bit(b);
    note("ignored after bad address", 16'h0001, {15'h0000, b}); // line left high
    $display("test abort and supply query done");
    tally_and_finish();
  end
endmodule // testbench
